//--- rtl/cpdi_ctrl.sv
// Control registers for power, de-emphasis and audio interface setup.
// Assumes a 3-wire port: latch, serial clock and data pins, MSB first,
// 16 bits per write (7 address, 9 data), taken on latch rising edge.
// Function
// - Three per-pair de-emphasis bits at 8:6, reset zero.
// - Global de-emphasis bit applies de-emphasis to all DAC pairs.
// - Global DAC power-down overrides per-pair disables.
// - Global power-down clears sample history, keeps all registers.
// - Clearing global power-down reinitialises DAC filters.
// - ADC disable bit holds ADC filters reset; reinit on release.
// - Three per-pair DAC disable bits at 3:1, reset zero.
// - Clearing a pair's disable reinitialises that pair's filters.
// - Master power-down bit 4 removes chip references.
// - Role bit 5 selects slave (0) or master (1), reset slave.
// - Master drives frame and bit clocks, held low while all three pairs are off; slave leaves them to source.
// - Ratio field 8:6 sets master clocks per frame, reset 256fs.
// - ADC format field 1:0 selects RJ, LJ, I2S or DSP.
// - ADC word length field 3:2 selects 16/20/24/32 bits.
// - ADC audio words are signed two's complement.
// - Frame polarity bit picks DSP mode A or B.
`include "cpdi_map.svh"
module cpdi_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ctl_latch,
  input wire logic ctl_clk,
  input wire logic ctl_data,
  input wire logic dac_frame_clock_in,
  input wire logic dac_bit_clock_in,
  output logic dac_frame_clock_out,
  output logic dac_frame_clock_oe,
  output logic dac_bit_clock_out,
  output logic dac_bit_clock_oe,
  output logic [2:0] dac_per_pair_sel_a_on,
  output logic [2:0] dac_pair_off,
  output logic [2:0] dac_filter_hold,
  output logic [2:0] dac_filter_reinit,
  output logic adc_off,
  output logic adc_filter_hold,
  output logic adc_filter_reinit,
  output logic chip_reference_powerdown,
  output logic [1:0] adc_format_sel,
  output logic [1:0] adc_word_length,
  output logic adc_dsp_mode_b,
  output logic adc_signed_words,
  output logic dac_frame_clock,
  output logic dac_bit_clock
);
  logic lat_s;
  logic clk_s;
  logic dat_s;
  logic clk_q;
  logic lat_q;
  logic [15:0] shreg;
  logic [8:0] dac_global_mute_per_pair_sel_a_pwr;
  logic [8:0] dac_per_pair_sel_a_select;
  logic [8:0] power_and_dac_iface_ctrl;
  logic [8:0] adc_iface_ctrl;
  logic [8:0] reg_adcctl;
  logic [6:0] wr_addr;
  logic [8:0] wr_data;
  logic all_dac_powerdown;
  logic [2:0] per_pair_dac_disable;
  logic [2:0] pair_off;
  logic [2:0] pair_hold;
  logic [2:0] pair_busy;
  logic adc_hold;
  logic adc_busy;
  logic dac_iface_role;
  logic [2:0] dac_clock_ratio;
  logic [9:0] frame_div;
  logic [9:0] mcnt;
  logic [9:0] next_mcnt;
  logic [2:0] bit_div;
  logic [9:0] bit_half;
  logic [9:0] bcnt;

  cpdi_sync u_lat (.sys_clk(sys_clk), .rst_n(rst_n), .pin(ctl_latch), .level(lat_s));
  cpdi_sync u_clk (.sys_clk(sys_clk), .rst_n(rst_n), .pin(ctl_clk), .level(clk_s));
  cpdi_sync u_dat (.sys_clk(sys_clk), .rst_n(rst_n), .pin(ctl_data), .level(dat_s));

  // Slave-role clocks enter through synchronisers; master-side logic ignores them
  cpdi_sync u_flc (.sys_clk(sys_clk), .rst_n(rst_n), .pin(dac_frame_clock_in),
    .level(dac_frame_clock));
  cpdi_sync u_bck (.sys_clk(sys_clk), .rst_n(rst_n), .pin(dac_bit_clock_in),
    .level(dac_bit_clock));

  assign wr_addr = shreg[15:9];
  assign wr_data = shreg[8:0];

  // Serial shift on rising control clock, MSB first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clk_q <= 1'b0;
      lat_q <= 1'b0;
      shreg <= 16'h0000;
    end else begin
      clk_q <= clk_s;
      lat_q <= lat_s;
      if (clk_s && !clk_q) begin
        shreg <= {shreg[14:0], dat_s};
      end
    end
  end

  // Register writes on rising latch; power-down never touches these
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dac_global_mute_per_pair_sel_a_pwr <= `CPDI_RST_GLOBAL;
      dac_per_pair_sel_a_select <= `CPDI_RST_PER_PAIR_SEL_A;
      power_and_dac_iface_ctrl <= `CPDI_RST_PWR;
      adc_iface_ctrl <= `CPDI_RST_ADCIF;
      reg_adcctl <= `CPDI_RST_ADCCTL;
    end else if (lat_s && !lat_q) begin
      case (wr_addr)
        `CPDI_ADDR_GLOBAL: dac_global_mute_per_pair_sel_a_pwr <= wr_data;
        `CPDI_ADDR_PER_PAIR_SEL_A: dac_per_pair_sel_a_select <= wr_data;
        `CPDI_ADDR_PWR: power_and_dac_iface_ctrl <= wr_data;
        `CPDI_ADDR_ADCIF: adc_iface_ctrl <= wr_data;
        `CPDI_ADDR_ADCCTL: reg_adcctl <= wr_data;
        default: dac_global_mute_per_pair_sel_a_pwr <= dac_global_mute_per_pair_sel_a_pwr;
      endcase
    end
  end

  // Field decode
  assign all_dac_powerdown = dac_global_mute_per_pair_sel_a_pwr[`CPDI_GLOBAL_PD_BIT];
  assign per_pair_dac_disable = power_and_dac_iface_ctrl[`CPDI_DAC_OFF_LSB +: 3];
  assign dac_iface_role = power_and_dac_iface_ctrl[`CPDI_ROLE_BIT];
  assign dac_clock_ratio = power_and_dac_iface_ctrl[`CPDI_RATIO_LSB +: 3];
  // Global power-down wins over the per-pair bits
  assign pair_off = per_pair_dac_disable | {3{all_dac_powerdown}};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pair
      // Release of the last set source reinitialises the pair
      cpdi_reinit u_re (.sys_clk(sys_clk), .rst_n(rst_n), .off(pair_off[gi]),
        .hold(pair_hold[gi]), .busy(pair_busy[gi]));
    end
  endgenerate

  cpdi_reinit u_adc_re (.sys_clk(sys_clk), .rst_n(rst_n),
    .off(power_and_dac_iface_ctrl[`CPDI_ADC_OFF_BIT]), .hold(adc_hold),
    .busy(adc_busy));

  // Registered control outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dac_per_pair_sel_a_on <= 3'h0;
      dac_pair_off <= 3'h0;
      dac_filter_hold <= 3'h0;
      dac_filter_reinit <= 3'h0;
      adc_off <= 1'b0;
      adc_filter_hold <= 1'b0;
      adc_filter_reinit <= 1'b0;
      chip_reference_powerdown <= 1'b0;
      adc_format_sel <= 2'h0;
      adc_word_length <= 2'h0;
      adc_dsp_mode_b <= 1'b0;
      adc_signed_words <= 1'b1;
    end else begin
      dac_per_pair_sel_a_on <= dac_per_pair_sel_a_select[`CPDI_PER_PAIR_SEL_A_LSB +: 3]
        | {3{dac_global_mute_per_pair_sel_a_pwr[`CPDI_GLOBAL_PER_PAIR_SEL_A_BIT]}};
      dac_pair_off <= pair_off;
      // Hold clears filter history while off
      dac_filter_hold <= pair_hold;
      dac_filter_reinit <= pair_busy;
      adc_off <= power_and_dac_iface_ctrl[`CPDI_ADC_OFF_BIT];
      adc_filter_hold <= adc_hold;
      adc_filter_reinit <= adc_busy;
      // Sequencing ADC/DAC first is left to software
      chip_reference_powerdown <= power_and_dac_iface_ctrl[`CPDI_CHIP_PD_BIT];
      adc_format_sel <= adc_iface_ctrl[`CPDI_FMT_LSB +: 2];
      adc_word_length <= adc_iface_ctrl[`CPDI_WL_LSB +: 2];
      // Only meaningful in DSP format
      adc_dsp_mode_b <= (cpdi_pkg::cpdi_fmt_t'(adc_iface_ctrl[`CPDI_FMT_LSB +: 2])
        == cpdi_pkg::CPDI_FMT_DSP) && reg_adcctl[`CPDI_POL_BIT];
      // Fixed flag: two's complement in every format
      adc_signed_words <= 1'b1;
    end
  end

  // Master clocks per frame for each ratio code; unused codes fall back to 256
  always_comb begin
    case (dac_clock_ratio)
      3'h0: frame_div = 10'd128;
      3'h1: frame_div = 10'd192;
      3'h2: frame_div = 10'd256;
      3'h3: frame_div = 10'd384;
      3'h4: frame_div = 10'd512;
      3'h5: frame_div = 10'd768;
      default: frame_div = 10'd256;
    endcase
  end

  // Bit clock at 64 per frame (32 per half, fits 32-bit words);
  // 192/768 ratios use 96 bit clocks per frame so the division stays exact
  always_comb begin
    case (dac_clock_ratio)
      3'h0: bit_div = 3'h1;
      3'h1: bit_div = 3'h1;
      3'h2: bit_div = 3'h2;
      3'h3: bit_div = 3'h3;
      3'h4: bit_div = 3'h4;
      3'h5: bit_div = 3'h4;
      default: bit_div = 3'h2;
    endcase
  end
  assign bit_half = {7'h00, bit_div};

  assign next_mcnt = (mcnt >= frame_div - 10'd1) ? 10'h000 : mcnt + 10'd1;

  // Master-role frame and bit clock generation
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !dac_iface_role || pair_off == 3'h7) begin
      mcnt <= 10'h000;
      bcnt <= 10'h000;
      dac_frame_clock_out <= 1'b0;
      dac_bit_clock_out <= 1'b0;
    end else begin
      mcnt <= next_mcnt;
      dac_frame_clock_out <= (next_mcnt < (frame_div >> 1));
      if (next_mcnt == 10'h000 || bcnt >= bit_half - 10'd1) begin
        bcnt <= 10'h000;
        dac_bit_clock_out <= (next_mcnt == 10'h000) ? 1'b0 : !dac_bit_clock_out;
      end else begin
        bcnt <= bcnt + 10'd1;
      end
    end
  end

  // Pins driven only in master role
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dac_frame_clock_oe <= 1'b0;
      dac_bit_clock_oe <= 1'b0;
    end else begin
      dac_frame_clock_oe <= dac_iface_role;
      dac_bit_clock_oe <= dac_iface_role;
    end
  end
endmodule : cpdi_ctrl

//--- rtl/cpdi_map.svh
// Register map, field positions, reset values and timing counts.
// Assumes 7-bit register addresses and 9-bit data words on the serial port.
`ifndef CPDI_MAP_SVH
`define CPDI_MAP_SVH
`define CPDI_ADDR_GLOBAL 7'h02
`define CPDI_ADDR_PER_PAIR_SEL_A 7'h09
`define CPDI_ADDR_PWR 7'h0a
`define CPDI_ADDR_ADCIF 7'h0b
`define CPDI_ADDR_ADCCTL 7'h0c
`define CPDI_GLOBAL_PER_PAIR_SEL_A_BIT 1
`define CPDI_GLOBAL_PD_BIT 2
`define CPDI_PER_PAIR_SEL_A_LSB 6
`define CPDI_ADC_OFF_BIT 0
`define CPDI_DAC_OFF_LSB 1
`define CPDI_CHIP_PD_BIT 4
`define CPDI_ROLE_BIT 5
`define CPDI_RATIO_LSB 6
`define CPDI_FMT_LSB 0
`define CPDI_WL_LSB 2
`define CPDI_POL_BIT 4
`define CPDI_RST_GLOBAL 9'h000
`define CPDI_RST_PER_PAIR_SEL_A 9'h000
`define CPDI_RST_PWR 9'h080
`define CPDI_RST_ADCIF 9'h000
`define CPDI_RST_ADCCTL 9'h000
`define CPDI_REINIT_CYCLES 8'h20
`endif

//--- rtl/cpdi_pkg.sv
// Types shared by the control block.
// Assumes the map header supplies every number except the enum encodings defined here.
package cpdi_pkg;
  typedef enum logic [1:0] {
    CPDI_FMT_RJ = 2'b00,
    CPDI_FMT_LJ = 2'b01,
    CPDI_FMT_I2S = 2'b10,
    CPDI_FMT_DSP = 2'b11
  } cpdi_fmt_t;
  typedef enum logic [1:0] {
    CPDI_SP_IDLE = 2'b00,
    CPDI_SP_SHIFT = 2'b01,
    CPDI_SP_DONE = 2'b10
  } cpdi_sp_t;
endpackage : cpdi_pkg

//--- rtl/cpdi_sync.sv
// Three-stage pin synchroniser; output changes once stages two and three agree.
// Assumes one clock domain on sys_clk.
module cpdi_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule : cpdi_sync

//--- rtl/cpdi_reinit.sv
// Filter hold-and-reinitialise sequencer for one audio path.
// Holds reset while disabled, then pulses a fixed reinit window on release.
`include "cpdi_map.svh"
module cpdi_reinit (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic off,
  output logic hold,
  output logic busy
);
  logic [7:0] cnt;
  logic off_d;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      off_d <= 1'b0;
      cnt <= 8'h00;
      hold <= 1'b0;
      busy <= 1'b0;
    end else begin
      off_d <= off;
      hold <= off;
      if (off) begin
        cnt <= 8'h00;
        busy <= 1'b0;
      end else if (off_d) begin
        cnt <= `CPDI_REINIT_CYCLES;
        busy <= 1'b1;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
        busy <= (cnt != 8'h01);
      end
    end
  end
endmodule : cpdi_reinit

//--- test/cpdi_ctrl_chk.sv
// Concurrent checks on the control block outputs.
// Assumes binding onto cpdi_ctrl, one clock and a synchronous reset.
module cpdi_ctrl_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic dac_frame_clock_oe,
  input wire logic dac_bit_clock_oe,
  input wire logic [2:0] dac_pair_off,
  input wire logic [2:0] dac_filter_hold,
  input wire logic [2:0] dac_filter_reinit,
  input wire logic adc_off,
  input wire logic adc_filter_hold,
  input wire logic adc_filter_reinit,
  input wire logic [1:0] adc_format_sel,
  input wire logic adc_dsp_mode_b,
  input wire logic adc_signed_words
);
  logic [7:0] run_len;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Length of the current reinit window on pair one
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      run_len <= 8'h00;
    end else begin
      run_len <= dac_filter_reinit[0] ? run_len + 8'h01 : 8'h00;
    end
  end
  chk_oe_pair: assert property (dac_frame_clock_oe == dac_bit_clock_oe)
    else $error("frame and bit clock enables differ");
  chk_pair_reinit: assert property ($fell(dac_pair_off[0])
    |-> ##[0:3] dac_filter_reinit[0])
    else $error("pair release without reinit");
  chk_reinit_len: assert property ($fell(dac_filter_reinit[0]) && $past(rst_n)
    |-> run_len == 8'd32)
    else $error("reinit window length wrong");
  chk_adc_reinit: assert property ($fell(adc_off) |-> ##[0:3] adc_filter_reinit)
    else $error("adc release without reinit");
  chk_adc_hold: assert property (adc_off && $past(adc_off, 3) |-> adc_filter_hold)
    else $error("adc filters not held");
  chk_pair_hold: assert property (dac_pair_off[1] && $past(dac_pair_off[1], 3)
    |-> dac_filter_hold[1])
    else $error("pair filters not held");
  chk_signed_words: assert property (adc_signed_words)
    else $error("sample words not signed");
  chk_dsp_mode: assert property (adc_dsp_mode_b |-> adc_format_sel == 2'b11)
    else $error("mode b outside dsp format");
endmodule : cpdi_ctrl_chk

bind cpdi_ctrl cpdi_ctrl_chk i_cpdi_ctrl_chk (.sys_clk, .rst_n, .dac_frame_clock_oe,
  .dac_bit_clock_oe, .dac_pair_off, .dac_filter_hold, .dac_filter_reinit, .adc_off,
  .adc_filter_hold, .adc_filter_reinit, .adc_format_sel, .adc_dsp_mode_b, .adc_signed_words);

//--- test/cpdi_ctrl_tb.sv
// Self-checking bench for the control block, writes through the 3-wire port.
// Assumes a 50 MHz clock and no read path: results are seen at the outputs.
module cpdi_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst_n = 1'b0, ctl_latch = 1'b0, ctl_clk = 1'b0, ctl_data = 1'b0;
  logic dac_frame_clock_in = 1'b0, dac_bit_clock_in = 1'b0;
  logic dac_frame_clock_out, dac_frame_clock_oe, dac_bit_clock_out, dac_bit_clock_oe;
  logic [2:0] dac_per_pair_sel_a_on, dac_pair_off, dac_filter_hold, dac_filter_reinit;
  logic adc_off, adc_filter_hold, adc_filter_reinit, chip_reference_powerdown;
  logic [1:0] adc_format_sel, adc_word_length;
  logic adc_dsp_mode_b, adc_signed_words, dac_frame_clock, dac_bit_clock;
  int n_errors = 0, comparisons = 0, cyc = 0, n, p, h;
  // Codes 110 and 111 fall back to 256fs; bit clock half periods per code
  int rat[8] = '{128, 192, 256, 384, 512, 768, 256, 256};
  int bh[8] = '{1, 1, 2, 3, 4, 4, 2, 2};

  cpdi_ctrl i_cpdi_ctrl (.sys_clk, .rst_n, .ctl_latch, .ctl_clk, .ctl_data,
    .dac_frame_clock_in, .dac_bit_clock_in, .dac_frame_clock_out, .dac_frame_clock_oe,
    .dac_bit_clock_out, .dac_bit_clock_oe, .dac_per_pair_sel_a_on, .dac_pair_off, .dac_filter_hold,
    .dac_filter_reinit, .adc_off, .adc_filter_hold, .adc_filter_reinit,
    .chip_reference_powerdown, .adc_format_sel, .adc_word_length, .adc_dsp_mode_b,
    .adc_signed_words, .dac_frame_clock, .dac_bit_clock);

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic cmp(input logic [11:0] got, input logic [11:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : cmp

  // Pin pulses of 4 cycles clear the 3-flop synchronisers with margin
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    logic [15:0] w;
    w = {a, d};
    for (int i = 15; i >= 0; i--) begin
      @(negedge sys_clk) ctl_data = w[i];
      repeat (4) @(negedge sys_clk);
      ctl_clk = 1'b1;
      repeat (4) @(negedge sys_clk);
      ctl_clk = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    ctl_latch = 1'b1;
    repeat (4) @(negedge sys_clk);
    ctl_latch = 1'b0;
    repeat (12) @(negedge sys_clk);
  endtask : wr

  // Cycles until the next rising frame clock edge
  task automatic rise(output int k);
    logic q;
    for (k = 1; k < 2000; k++) begin
      q = dac_frame_clock_out;
      @(posedge sys_clk);
      #1;
      if (!q && dac_frame_clock_out) break;
    end
  endtask : rise

  // Cycles from a frame clock rise until the bit clock first goes high
  task automatic half(output int k);
    for (k = 1; k < 20; k++) begin
      @(posedge sys_clk);
      #1;
      if (dac_bit_clock_out) break;
    end
  endtask : half

  initial begin
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    cmp({dac_per_pair_sel_a_on, dac_pair_off, dac_filter_hold}, 0, "reset dac");
    cmp({adc_off, chip_reference_powerdown, dac_frame_clock_oe}, 0,
      "reset pwr");
    cmp({adc_format_sel, adc_word_length, adc_signed_words}, 1,
      "reset adc");
    for (int c = 0; c < 8; c++) begin
      wr(7'h09, 9'(c << 6));
      cmp(dac_per_pair_sel_a_on, 12'(c), "pair per_pair_sel_a");
    end
    wr(7'h09, 9'h040);
    wr(7'h02, 9'h002);
    cmp(dac_per_pair_sel_a_on, 7, "global per_pair_sel_a");
    wr(7'h05, 9'h1ff);
    cmp({dac_per_pair_sel_a_on, dac_pair_off}, 12'h038, "unmapped write");
    wr(7'h02, 9'h004);
    cmp({dac_pair_off, dac_filter_hold, dac_per_pair_sel_a_on}, 12'h1f9,
      "global pd");
    wr(7'h02, 9'h000);
    cmp({dac_pair_off, dac_filter_reinit}, 7, "global pd release");
    p = 0;
    for (int c = 1; c < 9; c++) begin
      wr(7'h0a, 9'h080 | 9'((c & 7) << 1));
      cmp({dac_pair_off, dac_filter_reinit}, 12'(((c & 7) << 3) | (p & ~c & 7)), "pair");
      p = c & 7;
    end
    // Pairs and ADC go down before the references
    wr(7'h0a, 9'h08f);
    cmp({adc_off, adc_filter_hold, chip_reference_powerdown}, 6, "adc off");
    wr(7'h0a, 9'h09f);
    cmp({adc_off, chip_reference_powerdown, dac_pair_off}, 12'h1f, "chip pd");
    wr(7'h0a, 9'h080);
    cmp({adc_off, adc_filter_reinit, chip_reference_powerdown}, 2, "adc on");
    for (int c = 0; c < 16; c++) begin
      if (c != 12) begin
        wr(7'h0b, 9'(c));
        cmp({adc_word_length, adc_format_sel, adc_dsp_mode_b}, 12'(c << 1),
          "fmt");
      end
    end
    wr(7'h0c, 9'h010);
    cmp(adc_dsp_mode_b, 1, "dsp b");
    wr(7'h0b, 9'h002);
    cmp(adc_dsp_mode_b, 0, "i2s polarity");
    dac_frame_clock_in = 1'b1;
    dac_bit_clock_in = 1'b1;
    repeat (8) @(negedge sys_clk);
    cmp({dac_frame_clock, dac_bit_clock, dac_frame_clock_oe, dac_frame_clock_out,
      dac_bit_clock_out}, 12'h018, "slave high");
    dac_frame_clock_in = 1'b0;
    dac_bit_clock_in = 1'b0;
    repeat (8) @(negedge sys_clk);
    cmp({dac_frame_clock, dac_bit_clock}, 0, "slave low");
    for (int c = 0; c < 8; c++) begin
      wr(7'h0a, 9'((c << 6) | 32));
      cmp({dac_frame_clock_oe, dac_bit_clock_oe}, 3, "master oe");
      rise(n);
      rise(n);
      cmp(12'(n), 12'(rat[c]), "frame period");
      half(h);
      cmp(12'(h), 12'(bh[c]), "bit half period");
    end
    results();
  end
endmodule : cpdi_ctrl_tb
